/* File: src/hdg_descriptor_gen.sv */
`timescale 1ns/1ps
module hdg_descriptor_gen #(
  parameter int NUM_PORTS = hdg_pkg::HDG_PORTS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic descReq,
  input wire hdg_pkg::hdg_kind_t descKind,
  input wire logic [7:0] descType,
  input wire logic [15:0] descLen,
  output logic descReady,
  output logic descDone,
  output logic descStall,
  output logic byteValid,
  output logic [7:0] byteData,
  output logic byteLast,
  input wire logic byteReady
);
  import hdg_pkg::*;

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  // The bus-powered mask field starts at bit 4, so four ports at most.
  if (NUM_PORTS < 1 || NUM_PORTS > 4) begin : gBadPorts
    $error("NUM_PORTS must lie between 1 and 4");
  end

  typedef enum {
    ST_IDLE,
    ST_LOAD,
    ST_SEND
  } hdg_state_t;

  // ****************************************************************
  // Stored configuration
  // ****************************************************************
  logic powerSourceSelect_ff;
  logic portPowerSwitchMode_ff;
  logic compound_ff;
  logic [1:0] overcurrentSenseMode_ff;
  logic [NUM_PORTS-1:0] selfPoweredPortDisableMask_ff;
  logic [NUM_PORTS-1:0] busPoweredPortDisableMask_ff;

  // ****************************************************************
  // Wishbone slave
  // ****************************************************************
  logic ack_ff;
  logic [31:0] rdData_ff;

  wire busReq = wb_cyc_i & wb_stb_i;
  // Writes land on the edge where the master samples ack high.
  // Every field sits in the low byte lane, so sel[0] alone gates a write.
  wire busWrite = busReq & wb_we_i & ack_ff & wb_sel_i[0];
  wire hitCfg = (wb_adr_i == REG_CFG);
  wire hitMask = (wb_adr_i == REG_MASK);
  wire hitStat = (wb_adr_i == REG_STAT);
  wire hitLoad = (wb_adr_i == REG_LOAD);
  wire wrCfg = busWrite & hitCfg;
  wire wrMask = busWrite & hitMask;
  wire doDefault = busWrite & hitLoad & wb_dat_i[LOAD_BIT];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= busReq & ~ack_ff;
    end
  end

  // ****************************************************************
  // Configuration load
  // ****************************************************************
  // Reset and the default command both apply the built-in defaults;
  // the bus writes stand for the serial configuration load.
  always_ff @(posedge clk) begin
    if (!rst_n || doDefault) begin
      powerSourceSelect_ff <= RST_PSRC;
      portPowerSwitchMode_ff <= RST_PPS;
      compound_ff <= RST_COMP;
      overcurrentSenseMode_ff <= RST_OCS;
    end else if (wrCfg) begin
      powerSourceSelect_ff <= wb_dat_i[CFG_PSRC_BIT];
      portPowerSwitchMode_ff <= wb_dat_i[CFG_PPS_BIT];
      compound_ff <= wb_dat_i[CFG_COMP_BIT];
      overcurrentSenseMode_ff <= wb_dat_i[CFG_OCS_LSB +: 2];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || doDefault) begin
      selfPoweredPortDisableMask_ff <= RST_MASK_SP[NUM_PORTS-1:0];
      busPoweredPortDisableMask_ff <= RST_MASK_BP[NUM_PORTS-1:0];
    end else if (wrMask) begin
      selfPoweredPortDisableMask_ff <= wb_dat_i[MASK_SP_LSB +: NUM_PORTS];
      busPoweredPortDisableMask_ff <= wb_dat_i[MASK_BP_LSB +: NUM_PORTS];
    end
  end

  // ****************************************************************
  // Derived hub fields
  // ****************************************************************
  function automatic logic [7:0] countOnes(input logic [NUM_PORTS-1:0] v);
    logic [7:0] n;
    n = 8'h00;
    for (int i = 0; i < NUM_PORTS; i++) begin
      n = n + {7'h00, v[i]};
    end
    return n;
  endfunction

  // Flag 0 selects the bus-powered mask, flag 1 the self-powered one.
  wire [NUM_PORTS-1:0] activeMask = powerSourceSelect_ff ?
      selfPoweredPortDisableMask_ff :
      busPoweredPortDisableMask_ff;
  // Disabled ports are dropped from the count, not renumbered.
  wire [7:0] totalPorts = 8'(NUM_PORTS);
  wire [7:0] portCount = totalPorts - countOnes(activeMask);
  wire [1:0] ppsField = portPowerSwitchMode_ff ?
      CHAR_PPS_INDIV : CHAR_PPS_GANGED;
  // Think time and indicator bits are fixed; only loaded settings vary.
  wire [15:0] hubChar = {
    CHAR_HIGH,
    CHAR_NO_INDICATOR,
    CHAR_TT_8FS,
    overcurrentSenseMode_ff,
    compound_ff,
    ppsField
  };

  // ****************************************************************
  // Register read path
  // ****************************************************************
  logic stateBusy;
  wire [31:0] cfgWord = 32'({overcurrentSenseMode_ff, compound_ff,
      portPowerSwitchMode_ff, powerSourceSelect_ff});
  wire [31:0] maskWord =
      (32'(busPoweredPortDisableMask_ff) << MASK_BP_LSB) |
      (32'(selfPoweredPortDisableMask_ff) << MASK_SP_LSB);
  // Busy tells software that a transfer may be reading the live settings.
  wire [31:0] statWord = (32'(stateBusy) << STAT_BUSY_BIT) |
      (32'(hubChar) << STAT_CHAR_LSB) |
      (32'(portCount) << STAT_CNT_LSB);
  // Unmapped addresses and the load register read as zero.
  wire [31:0] rdMux = hitCfg ? cfgWord :
      hitMask ? maskWord :
      hitStat ? statWord : 32'h0000_0000;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdData_ff <= 32'h0000_0000;
    end else if (busReq & ~ack_ff) begin
      rdData_ff <= rdMux;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdData_ff;

  // ****************************************************************
  // Descriptor table
  // ****************************************************************
  // The table holds no state; all sequencing stays in this module.
  hdg_tbl_if tblBus ();

  hdg_byte_table uTable (
    .tbl(tblBus.lookup)
  );

  hdg_state_t state_ff;
  hdg_state_t nxt_state;
  hdg_kind_t kind_ff;
  logic [3:0] offset_ff;
  logic [15:0] remain_ff;
  logic byteValid_ff;
  logic [7:0] byteData_ff;
  logic byteLast_ff;
  logic done_ff;
  logic stall_ff;

  assign tblBus.kind = (state_ff == ST_IDLE) ? descKind : kind_ff;
  assign tblBus.offset = offset_ff;
  assign tblBus.portCount = portCount;
  assign tblBus.hubChar = hubChar;

  // ****************************************************************
  // Request decode
  // ****************************************************************
  // The table size does not depend on offset, so it is read with the
  // incoming kind before the request is stored.
  wire hubTypeOk = (descType == HUB_TYPE) ||
      (descType == HUB_TYPE_LEGACY);
  wire reqBad = (descKind == HDG_KIND_HUB) ? ~hubTypeOk :
      ~((descKind == HDG_KIND_EP) || (descKind == HDG_KIND_IFMTT));
  wire [15:0] reqSize = 16'(tblBus.tblSize);
  wire [15:0] reqCount = (descLen < reqSize) ? descLen : reqSize;
  // Requests that arrive while busy are dropped, not queued.
  wire take = descReq & (state_ff == ST_IDLE);
  wire takeGood = take & ~reqBad & (reqCount != 16'h0000);
  wire takeEmpty = take & ~reqBad & (reqCount == 16'h0000);
  wire handshake = byteValid_ff & byteReady;
  wire lastSent = handshake & byteLast_ff;

  assign descReady = (state_ff == ST_IDLE);
  assign stateBusy = (state_ff != ST_IDLE);

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (takeGood) begin
          nxt_state = ST_LOAD;
        end
      end
      ST_LOAD: begin
        nxt_state = ST_SEND;
      end
      ST_SEND: begin
        if (lastSent) begin
          nxt_state = ST_IDLE;
        end else if (handshake) begin
          nxt_state = ST_LOAD;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      kind_ff <= HDG_KIND_EP;
      offset_ff <= 4'h0;
      remain_ff <= 16'h0000;
    end else if (takeGood) begin
      kind_ff <= descKind;
      offset_ff <= 4'h0;
      remain_ff <= reqCount;
    end else if (handshake) begin
      offset_ff <= offset_ff + 4'h1;
      remain_ff <= remain_ff - 16'h0001;
    end
  end

  // ****************************************************************
  // Byte output
  // ****************************************************************
  // Each byte costs a load cycle; enumeration traffic is slow, so the
  // simpler registered path was preferred over a prefetch.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      byteValid_ff <= 1'b0;
      byteData_ff <= 8'h00;
      byteLast_ff <= 1'b0;
    end else if (state_ff == ST_LOAD) begin
      byteValid_ff <= 1'b1;
      byteData_ff <= tblBus.tblByte;
      byteLast_ff <= (remain_ff == 16'h0001);
    end else if (handshake) begin
      byteValid_ff <= 1'b0;
      byteLast_ff <= 1'b0;
    end
  end

  // A zero-length request ends at once, with no byte on the port.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      done_ff <= 1'b0;
      stall_ff <= 1'b0;
    end else begin
      done_ff <= lastSent | takeEmpty;
      stall_ff <= take & reqBad;
    end
  end

  assign byteValid = byteValid_ff;
  assign byteData = byteData_ff;
  assign byteLast = byteLast_ff;
  assign descDone = done_ff;
  assign descStall = stall_ff;

endmodule

/* File: src/hdg_pkg.sv */
package hdg_pkg;

  // ****************************************************************
  // Descriptor kinds
  // ****************************************************************
  typedef enum logic [1:0] {
    HDG_KIND_EP,
    HDG_KIND_IFMTT,
    HDG_KIND_HUB
  } hdg_kind_t;

  localparam int HDG_PORTS = 3;

  // ****************************************************************
  // Descriptor content
  // ****************************************************************
  localparam logic [7:0] EP_LEN = 8'h07;
  localparam logic [7:0] EP_TYPE = 8'h05;
  localparam logic [7:0] EP_ADDR = 8'h81;
  localparam logic [7:0] EP_ATTR = 8'h03;
  localparam logic [15:0] EP_MPS = 16'h0001;
  localparam logic [7:0] EP_INTERVAL = 8'h0c;
  localparam logic [3:0] EP_SIZE = 4'h7;

  localparam logic [7:0] IF_LEN = 8'h09;
  localparam logic [7:0] IF_TYPE = 8'h04;
  localparam logic [7:0] IF_NUM = 8'h00;
  localparam logic [7:0] IF_ALT = 8'h01;
  localparam logic [7:0] IF_NEP = 8'h01;
  localparam logic [7:0] IF_CLASS = 8'h09;
  localparam logic [7:0] IF_SUBCLASS = 8'h00;
  localparam logic [7:0] IF_PROTO_MTT = 8'h02;
  localparam logic [7:0] IF_STRING = 8'h00;
  localparam logic [3:0] IF_SIZE = 4'h9;

  localparam logic [7:0] HUB_LEN = 8'h09;
  localparam logic [7:0] HUB_TYPE = 8'h29;
  localparam logic [7:0] HUB_TYPE_LEGACY = 8'h00;
  localparam logic [3:0] HUB_SIZE_SERVED = 4'h5;

  // ****************************************************************
  // Hub characteristics layout
  // ****************************************************************
  localparam logic [1:0] CHAR_PPS_GANGED = 2'h0;
  localparam logic [1:0] CHAR_PPS_INDIV = 2'h1;
  localparam logic [1:0] CHAR_TT_8FS = 2'h0;
  localparam logic CHAR_NO_INDICATOR = 1'b0;
  localparam logic [7:0] CHAR_HIGH = 8'h00;

  // ****************************************************************
  // Register map and fields
  // ****************************************************************
  localparam logic [7:0] REG_CFG = 8'h00;
  localparam logic [7:0] REG_MASK = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [7:0] REG_LOAD = 8'h0c;

  localparam int CFG_PSRC_BIT = 0;
  localparam int CFG_PPS_BIT = 1;
  localparam int CFG_COMP_BIT = 2;
  localparam int CFG_OCS_LSB = 3;
  localparam int MASK_SP_LSB = 0;
  localparam int MASK_BP_LSB = 4;
  localparam int STAT_CNT_LSB = 0;
  localparam int STAT_CHAR_LSB = 8;
  localparam int STAT_BUSY_BIT = 24;
  localparam int LOAD_BIT = 0;

  localparam logic RST_PSRC = 1'b1;
  localparam logic RST_PPS = 1'b1;
  localparam logic RST_COMP = 1'b0;
  localparam logic [1:0] RST_OCS = 2'h1;
  localparam logic [3:0] RST_MASK_SP = 4'h0;
  localparam logic [3:0] RST_MASK_BP = 4'h0;

endpackage

/* File: src/hdg_tbl_if.sv */
`timescale 1ns/1ps
interface hdg_tbl_if;
  import hdg_pkg::*;
  hdg_kind_t kind;
  logic [3:0] offset;
  logic [7:0] portCount;
  logic [15:0] hubChar;
  logic [7:0] tblByte;
  logic [3:0] tblSize;

  modport gen (
    output kind,
    output offset,
    output portCount,
    output hubChar,
    input tblByte,
    input tblSize
  );

  modport lookup (
    input kind,
    input offset,
    input portCount,
    input hubChar,
    output tblByte,
    output tblSize
  );
endinterface

/* File: src/hdg_byte_table.sv */
`timescale 1ns/1ps
module hdg_byte_table (
  hdg_tbl_if.lookup tbl
);
  import hdg_pkg::*;

  // ****************************************************************
  // Byte lookup per descriptor kind and offset
  // ****************************************************************
  always_comb begin
    tbl.tblByte = 8'h00;
    tbl.tblSize = 4'h0;
    case (tbl.kind)
      HDG_KIND_EP: begin
        tbl.tblSize = EP_SIZE;
        case (tbl.offset)
          4'h0: tbl.tblByte = EP_LEN;
          4'h1: tbl.tblByte = EP_TYPE;
          4'h2: tbl.tblByte = EP_ADDR;
          4'h3: tbl.tblByte = EP_ATTR;
          4'h4: tbl.tblByte = EP_MPS[7:0];
          4'h5: tbl.tblByte = EP_MPS[15:8];
          4'h6: tbl.tblByte = EP_INTERVAL;
          default: tbl.tblByte = 8'h00;
        endcase
      end
      HDG_KIND_IFMTT: begin
        tbl.tblSize = IF_SIZE;
        case (tbl.offset)
          4'h0: tbl.tblByte = IF_LEN;
          4'h1: tbl.tblByte = IF_TYPE;
          4'h2: tbl.tblByte = IF_NUM;
          4'h3: tbl.tblByte = IF_ALT;
          4'h4: tbl.tblByte = IF_NEP;
          4'h5: tbl.tblByte = IF_CLASS;
          4'h6: tbl.tblByte = IF_SUBCLASS;
          4'h7: tbl.tblByte = IF_PROTO_MTT;
          4'h8: tbl.tblByte = IF_STRING;
          default: tbl.tblByte = 8'h00;
        endcase
      end
      HDG_KIND_HUB: begin
        tbl.tblSize = HUB_SIZE_SERVED;
        case (tbl.offset)
          4'h0: tbl.tblByte = HUB_LEN;
          4'h1: tbl.tblByte = HUB_TYPE;
          4'h2: tbl.tblByte = tbl.portCount;
          4'h3: tbl.tblByte = tbl.hubChar[7:0];
          4'h4: tbl.tblByte = tbl.hubChar[15:8];
          default: tbl.tblByte = 8'h00;
        endcase
      end
      default: begin
        tbl.tblByte = 8'h00;
        tbl.tblSize = 4'h0;
      end
    endcase
  end
endmodule

/* File: tb/hdg_assertions.sv */
`timescale 1ns/1ps
module hdg_assertions (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic descReq,
  input wire hdg_pkg::hdg_kind_t descKind,
  input wire logic [7:0] descType,
  input wire logic [15:0] descLen,
  input wire logic descReady,
  input wire logic descDone,
  input wire logic descStall,
  input wire logic byteValid,
  input wire logic [7:0] byteData,
  input wire logic byteReady
);
  import hdg_pkg::*;
  wire logic take = descReq && descReady;
  wire logic isHub = descKind == HDG_KIND_HUB;
  wire logic hubOk = descType == 8'h29 || descType == 8'h00;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ********
  // Bus and descriptor port
  // ********
  a_ack_next: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  a_ack_single: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_stall_bad: assert property (
    take && isHub && !hubOk |=> descStall)
    else $error("bad hub type not refused");
  a_hub_first: assert property (
    take && isHub && hubOk && descLen != 16'h0
    |=> !descStall ##1 byteValid && byteData == 8'h09)
    else $error("hub descriptor start wrong");
  a_ep_first: assert property (
    take && descKind == HDG_KIND_EP && descLen != 16'h0
    |=> ##1 byteValid && byteData == 8'h07)
    else $error("endpoint start wrong");
  a_if_first: assert property (
    take && descKind == HDG_KIND_IFMTT && descLen != 16'h0
    |=> ##1 byteValid && byteData == 8'h09)
    else $error("interface start wrong");
  // A stalled byte must not move, or the host would lose or repeat data.
  a_byte_hold: assert property (
    byteValid && !byteReady |=> byteValid && $stable(byteData))
    else $error("byte changed while stalled");
  a_zero_done: assert property (
    take && descLen == 16'h0 && (!isHub || hubOk) |=> descDone)
    else $error("empty transfer not done");
  a_busy_flag: assert property (
    byteValid |-> !descReady)
    else $error("ready while sending");
endmodule

bind hdg_descriptor_gen hdg_assertions chk (
  .clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .descReq(descReq), .descKind(descKind),
  .descType(descType), .descLen(descLen), .descReady(descReady),
  .descDone(descDone), .descStall(descStall), .byteValid(byteValid),
  .byteData(byteData), .byteReady(byteReady)
);

/* File: tb/hdg_host_model.sv */
`timescale 1ns/1ps
module hdg_host_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic stall,
  input wire logic byteValid,
  input wire logic [7:0] byteData,
  input wire logic byteLast,
  output logic byteReady
);
  logic [7:0] got[$];
  int lastPos;
  // ********
  // Byte sink
  // ********
  // A stalling host toggles ready, so bytes are held across refusals.
  always @(posedge clk) begin
    if (!rst_n) begin
      byteReady <= 1'h0;
      lastPos <= -1;
    end else begin
      byteReady <= stall ? ~byteReady : 1'h1;
      if (byteValid && byteReady) begin
        if (byteLast) begin
          lastPos <= got.size();
        end
        got.push_back(byteData);
      end
    end
  end
endmodule

/* File: tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import hdg_pkg::*;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic wbCyc = 1'h0;
  logic wbStb = 1'h0;
  logic wbWe = 1'h0;
  logic [7:0] wbAdr = 8'h00;
  logic [31:0] wbDatW = 32'h0;
  logic [3:0] wbSel = 4'hf;
  logic [31:0] wbDatR, rd, expStat;
  logic wbAck, descReady, descDone, descStall;
  logic descReq = 1'h0;
  hdg_kind_t descKind = HDG_KIND_EP;
  logic [7:0] descType = 8'h00;
  logic [15:0] descLen = 16'h0;
  logic byteValid, byteLast, byteReady, sawStall;
  logic [7:0] byteData;
  logic hostStall = 1'h0;
  logic [7:0] exp[$];
  int errorCnt = 0;
  int numChecks = 0;

  always #25 clk = ~clk;

  hdg_descriptor_gen dut (
    .clk(clk), .rst_n(rst_n), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_dat_i(wbDatW), .wb_sel_i(wbSel),
    .wb_dat_o(wbDatR), .wb_ack_o(wbAck), .descReq(descReq),
    .descKind(descKind), .descType(descType), .descLen(descLen),
    .descReady(descReady), .descDone(descDone), .descStall(descStall),
    .byteValid(byteValid), .byteData(byteData), .byteLast(byteLast),
    .byteReady(byteReady)
  );

  hdg_host_model host (
    .clk(clk), .rst_n(rst_n), .stall(hostStall), .byteValid(byteValid),
    .byteData(byteData), .byteLast(byteLast), .byteReady(byteReady)
  );

  // ********
  // Tasks
  // ********
  task automatic results();
    if (errorCnt == 0 && numChecks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    numChecks++;
    if (g !== e) begin
      errorCnt++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wbAcc(logic we, logic [7:0] a, logic [31:0] d,
                       logic [3:0] s);
    int n;
    @(posedge clk);
    wbCyc <= 1'h1;
    wbStb <= 1'h1;
    wbWe <= we;
    wbAdr <= a;
    wbDatW <= d;
    wbSel <= s;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wbAck !== 1'h1);
    rd = wbDatR;
    chk("ack", 32'h2, 32'(n));
    wbCyc <= 1'h0;
    wbStb <= 1'h0;
  endtask

  task automatic desc(hdg_kind_t k, logic [7:0] t, logic [15:0] l);
    @(posedge clk);
    host.got.delete();
    descReq <= 1'h1;
    descKind <= k;
    descType <= t;
    descLen <= l;
    @(posedge clk);
    descReq <= 1'h0;
    do begin
      @(posedge clk);
      sawStall = descStall;
    end while (descDone !== 1'h1 && descStall !== 1'h1);
  endtask

  task automatic chkBytes();
    chk("count", 32'(exp.size()), 32'(host.got.size()));
    foreach (exp[i]) begin
      if (i < host.got.size()) begin
        chk("byte", {24'h0, exp[i]}, {24'h0, host.got[i]});
      end
    end
    if (exp.size() > 0) begin
      chk("last", 32'(exp.size() - 1), 32'(host.lastPos));
    end
  endtask

  // ********
  // Tests
  // ********
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'h1;
    wbAcc(1'h0, REG_STAT, 32'h0, 4'hf);
    chk("stat", 32'h00000903, rd);
    wbAcc(1'h0, 8'h10, 32'h0, 4'hf);
    chk("unmapped", 32'h0, rd);
    hostStall <= 1'h1;
    exp = '{8'h07, 8'h05, 8'h81, 8'h03, 8'h01, 8'h00, 8'h0c};
    desc(HDG_KIND_EP, 8'h00, 16'h0007);
    chkBytes();
    exp = exp[0:4];
    desc(HDG_KIND_EP, 8'h29, 16'h0005);
    chkBytes();
    hostStall <= 1'h0;
    exp = '{8'h09, 8'h04, 8'h00, 8'h01, 8'h01, 8'h09, 8'h00, 8'h02, 8'h00};
    desc(HDG_KIND_IFMTT, 8'h00, 16'h00ff);
    chkBytes();
    for (int i = 0; i < 4; i++) begin
      logic [4:0] c;
      logic [2:0] sp, bp, act;
      logic [7:0] ch;
      c = {i[1:0], ~i[0], i[1], i[0]};
      sp = 3'(i + 1);
      bp = 3'(7 - i);
      act = c[0] ? sp : bp;
      ch = {3'h0, c[4:3], c[2], 1'h0, c[1]};
      wbAcc(1'h1, REG_CFG, {27'h0, c}, 4'hf);
      wbAcc(1'h1, REG_MASK, {25'h0, bp, 1'h0, sp}, 4'hf);
      wbAcc(1'h0, REG_CFG, 32'h0, 4'hf);
      chk("cfg", {27'h0, c}, rd);
      wbAcc(1'h0, REG_MASK, 32'h0, 4'hf);
      chk("mask", {25'h0, bp, 1'h0, sp}, rd);
      exp = '{8'h09, 8'h29, 8'(3 - $countones(act)), ch, 8'h00};
      hostStall <= i[1];
      desc(HDG_KIND_HUB, i[0] ? 8'h29 : 8'h00, 16'h0009);
      chkBytes();
      expStat = {16'h0, ch, exp[2]};
      wbAcc(1'h0, REG_STAT, 32'h0, 4'hf);
      chk("stat", expStat, rd);
    end
    exp.delete();
    desc(HDG_KIND_HUB, 8'h22, 16'h0009);
    chk("stall", 32'h1, {31'h0, sawStall});
    chkBytes();
    desc(HDG_KIND_EP, 8'h00, 16'h0000);
    chk("stall", 32'h0, {31'h0, sawStall});
    chkBytes();
    // With sel[0] low the write must leave the loaded settings alone.
    wbAcc(1'h1, REG_CFG, 32'h0, 4'h0);
    wbAcc(1'h0, REG_STAT, 32'h0, 4'hf);
    chk("stat", expStat, rd);
    wbAcc(1'h1, REG_LOAD, 32'h1, 4'hf);
    wbAcc(1'h0, REG_STAT, 32'h0, 4'hf);
    chk("stat", 32'h00000903, rd);
    wbAcc(1'h0, REG_CFG, 32'h0, 4'hf);
    chk("cfg", 32'h0000000b, rd);
    wbAcc(1'h0, REG_MASK, 32'h0, 4'hf);
    chk("mask", 32'h0, rd);
    results();
  end

  initial begin
    repeat (5000) @(posedge clk);
    errorCnt++;
    results();
  end
endmodule
